// ===== core/cms_msg_slot.sv
// Function
// - Send summary bit sets on slot send completion, resets to zero
// - Writing one to send summary clear drops the summary bit
// - Send summary bit and slot send-done flag are one storage element
// - Control bit 5: 0 auto transmit, 1 auto receive
// - Control bit 4: 0 reception, 1 transmission
// - Status clear bit 3 resets replaced flag; zero no change
// - Status clear bit 2 resets length mismatch flag; zero no change
// - Status clear bit 1 resets send-done flag; zero no change
// - Status clear bit 0 resets recv-done flag; zero no change
// - Replaced flag raised on overwrite only while replace enable is on
// - Length mismatch raised when received length differs from programmed
// - Send-done raised only after error-free transmission
// - Recv-done raised only after error-free reception
// - Recv summary bit mirrors slot recv-done flag
// - Send summary clear: one clears, zero has no effect
`timescale 1ns/10ps
`include "cms_defs.svh"
module cms_msg_slot #(
  parameter int SLOTS = 16,
  parameter logic [31:0] VERSION_ID = 32'h0000_0001 // Arbitrary value
)(
  input wire logic clk,                    // 125 MHz clock
  input wire logic reset,                  // Async reset, active high
  input wire logic [7:0] addr,             // Register byte address
  input wire logic [31:0] wrData,          // Write data
  input wire logic wrStrobe,               // Write strobe
  input wire logic rdStrobe,               // Read strobe
  output logic [31:0] rdData,              // Read data, cycle after strobe
  input wire logic [SLOTS-1:0] sendOk,     // Error-free send done pulse
  input wire logic [SLOTS-1:0] recvOk,     // Error-free receive done pulse
  input wire logic [SLOTS-1:0] overwrote,  // Receive replaced old message
  input wire logic [3:0] rxLength,         // Length code of received frame
  output logic [SLOTS-1:0] autoRecv,       // Auto behaviour per slot
  output logic [SLOTS-1:0] dirSend,        // Direction per slot
  output logic [4*SLOTS-1:0] slotLength,   // Programmed length per slot
  output logic replaceEnable,              // Global replace enable
  output logic irq                         // Level interrupt
);
  cms_pkg::cms_ctrl_s ctrl [SLOTS];
  cms_pkg::cms_flags_s flags [SLOTS];
  logic [SLOTS-1:0] sendSum;
  logic [SLOTS-1:0] recvSum;
  logic [SLOTS-1:0] lenEvent;
  logic [3:0] irqStat;
  logic [3:0] irqEn;
  logic [3:0] next_irqStat;
  logic [31:0] next_rdData;

  // twelve-byte stride
  // Nine-bit sum so that high slots never wrap onto the global registers;
  // slots beyond the 8-bit address reach are simply not addressable
  function automatic logic slotHit(input logic [7:0] a, input logic [7:0] b,
                                   input int s);
    logic [8:0] ofs;
    ofs = {1'b0, b} + 9'(s * 12);
    return {1'b0, a} == ofs;
  endfunction

  genvar g;
  generate
    for (g = 0; g < SLOTS; g++)
    begin : gSlot
      logic ctrlWr;
      logic clrWr;
      assign ctrlWr = wrStrobe && slotHit(addr, `CMS_CTRL_BASE, g);
      assign clrWr = wrStrobe && slotHit(addr, `CMS_SCLR_BASE, g);
      always_ff @(posedge clk or posedge reset)
      begin
        if (reset)
          ctrl[g] <= '0;
        else if (ctrlWr)
          ctrl[g] <= {wrData[`CMS_BIT_AUTO], wrData[`CMS_BIT_DIR],
                      wrData[3:0]};
      end
      // length range is software's duty; stored as written
      assign autoRecv[g] = ctrl[g].autoRecv;
      assign dirSend[g] = ctrl[g].dirSend;
      assign slotLength[4*g +: 4] = ctrl[g].dlc;
      // summary is the same flop as send-done
      assign sendSum[g] = flags[g].sendDone;
      assign recvSum[g] = flags[g].recvDone;
      // length compared only on a receive pulse
      assign lenEvent[g] = recvOk[g] && rxLength != ctrl[g].dlc;
      always_ff @(posedge clk or posedge reset)
      begin
        if (reset)
          flags[g] <= '0;
        else
        begin
          // set wins over clear; clear bits
          if (overwrote[g] && replaceEnable)
            flags[g].replaced <= 1'b1;
          else if (clrWr && wrData[`CMS_BIT_OVW])
            flags[g].replaced <= 1'b0;
          if (lenEvent[g])
            flags[g].lenMismatch <= 1'b1;
          else if (clrWr && wrData[`CMS_BIT_LENW])
            flags[g].lenMismatch <= 1'b0;
          if (sendOk[g])
            flags[g].sendDone <= 1'b1;
          else if ((clrWr && wrData[`CMS_BIT_SEND_DONE_FLAG]) ||
                   (wrStrobe && addr == `CMS_TXSUM_CLR_OFS && wrData[g]))
            flags[g].sendDone <= 1'b0;
          if (recvOk[g])
            flags[g].recvDone <= 1'b1;
          else if ((clrWr && wrData[`CMS_BIT_RECV_DONE_FLAG]) ||
                   (wrStrobe && addr == `CMS_RXSUM_CLR_OFS && wrData[g]))
            flags[g].recvDone <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      replaceEnable <= 1'b0;
    else if (wrStrobe && addr == `CMS_GCFG_OFS)
      replaceEnable <= wrData[0];
  end

  // Events per class: send, recv, length mismatch, replaced
  always_comb
  begin
    next_irqStat = irqStat;
    if (wrStrobe && addr == `CMS_IRQ_CLR_OFS)
      next_irqStat = irqStat & ~wrData[3:0];
    next_irqStat = next_irqStat | {|(overwrote & {SLOTS{replaceEnable}}),
                                   |lenEvent, |recvOk, |sendOk};
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      irqStat <= '0;
      irqEn <= '0;
    end
    else
    begin
      irqStat <= next_irqStat;
      if (wrStrobe && addr == `CMS_IRQ_EN_OFS)
        irqEn <= wrData[3:0];
    end
  end

  assign irq = |(irqStat & irqEn);

  always_comb
  begin
    next_rdData = `CMS_RESET_VAL;
    case (addr)
      `CMS_TXSUM_OFS: next_rdData[SLOTS-1:0] = sendSum;
      `CMS_RXSUM_OFS: next_rdData[SLOTS-1:0] = recvSum;
      `CMS_GCFG_OFS: next_rdData[0] = replaceEnable;
      `CMS_IRQ_STAT_OFS: next_rdData[3:0] = irqStat;
      `CMS_IRQ_EN_OFS: next_rdData[3:0] = irqEn;
      `CMS_VERSION_OFS: next_rdData = VERSION_ID;
      default: next_rdData = `CMS_RESET_VAL;
    endcase
    for (int s = 0; s < SLOTS; s++)
    begin
      if (slotHit(addr, `CMS_CTRL_BASE, s))
        next_rdData[5:0] = ctrl[s];
      if (slotHit(addr, `CMS_STAT_BASE, s))
        next_rdData[3:0] = flags[s];
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      rdData <= '0;
    else if (rdStrobe)
      rdData <= next_rdData;
    else
      rdData <= '0;
  end

  AST_SEND_SET: assert property (@(posedge clk) disable iff (reset)
    sendOk[0] |=> sendSum[0] && flags[0].sendDone)
    else $error("send done not set");
  AST_SET_WINS: assert property (@(posedge clk) disable iff (reset)
    (sendOk[0] && wrStrobe && addr == `CMS_TXSUM_CLR_OFS) |=> sendSum[0])
    else $error("set lost to clear");
  AST_SUM_CLR: assert property (@(posedge clk) disable iff (reset)
    (!sendOk[0] && wrStrobe && addr == `CMS_TXSUM_CLR_OFS && wrData[0])
    |=> !sendSum[0])
    else $error("summary not cleared");
  AST_OVW_GATE: assert property (@(posedge clk) disable iff (reset)
    (!flags[0].replaced && !replaceEnable) |=> !flags[0].replaced)
    else $error("replace flag set while disabled");
  AST_LEN: assert property (@(posedge clk) disable iff (reset)
    (recvOk[0] && rxLength != ctrl[0].dlc) |=> flags[0].lenMismatch)
    else $error("length mismatch missed");
  AST_RX_CLR: assert property (@(posedge clk) disable iff (reset)
    (!recvOk[0] && wrStrobe && addr == `CMS_SCLR_BASE && wrData[0])
    |=> !flags[0].recvDone)
    else $error("recv done not cleared");
  AST_MIRROR: assert property (@(posedge clk) disable iff (reset)
    (rdStrobe && addr == `CMS_RXSUM_OFS) |=> rdData[0] == $past(recvSum[0]))
    else $error("recv summary mismatch");
  AST_CTRL: assert property (@(posedge clk) disable iff (reset)
    (wrStrobe && addr == `CMS_CTRL_BASE) |=>
    dirSend[0] == $past(wrData[4]) && autoRecv[0] == $past(wrData[5]))
    else $error("control not stored");
  CV_SEND: cover property (@(posedge clk) sendOk[0] ##1 sendSum[0]);
  CV_IRQ: cover property (@(posedge clk) irq);
  CV_OVW: cover property (@(posedge clk) flags[0].replaced);
  CV_LEN: cover property (@(posedge clk) lenEvent[0]);
  CV_RX: cover property (@(posedge clk) recvOk[0] ##1 recvSum[0]);

  // Replaced flag: set, clear and hold
  AST_OVW_SET: assert property (@(posedge clk) disable iff (reset)
    (overwrote[0] && replaceEnable)
    |=> flags[0].replaced)
    else $error("replace flag not set");

  AST_OVW_ONLY: assert property (@(posedge clk) disable iff (reset)
    (!flags[0].replaced && !overwrote[0])
    |=> !flags[0].replaced)
    else $error("replace flag set without event");

  AST_OVW_CLR: assert property (@(posedge clk) disable iff (reset)
    (!(overwrote[0] && replaceEnable) && wrStrobe &&
     addr == `CMS_SCLR_BASE && wrData[3])
    |=> !flags[0].replaced)
    else $error("replace flag not cleared");

  AST_OVW_KEEP: assert property (@(posedge clk) disable iff (reset)
    (flags[0].replaced &&
     !(wrStrobe && addr == `CMS_SCLR_BASE && wrData[3]))
    |=> flags[0].replaced)
    else $error("replace flag lost");

  // Length mismatch flag
  AST_LEN_CLR: assert property (@(posedge clk) disable iff (reset)
    (!lenEvent[0] && wrStrobe && addr == `CMS_SCLR_BASE && wrData[2])
    |=> !flags[0].lenMismatch)
    else $error("length flag not cleared");

  AST_LEN_KEEP: assert property (@(posedge clk) disable iff (reset)
    (flags[0].lenMismatch &&
     !(wrStrobe && addr == `CMS_SCLR_BASE && wrData[2]))
    |=> flags[0].lenMismatch)
    else $error("length flag lost");

  AST_LEN_ONLY: assert property (@(posedge clk) disable iff (reset)
    (!flags[0].lenMismatch && !(recvOk[0] && rxLength != ctrl[0].dlc))
    |=> !flags[0].lenMismatch)
    else $error("length flag set without mismatch");

  // Send-done flag
  AST_TX_CLR: assert property (@(posedge clk) disable iff (reset)
    (!sendOk[0] && wrStrobe && addr == `CMS_SCLR_BASE && wrData[1])
    |=> !flags[0].sendDone)
    else $error("send done not cleared");

  AST_TX_KEEP: assert property (@(posedge clk) disable iff (reset)
    (flags[0].sendDone && !(wrStrobe &&
     ((addr == `CMS_SCLR_BASE && wrData[1]) ||
      (addr == `CMS_TXSUM_CLR_OFS && wrData[0]))))
    |=> flags[0].sendDone)
    else $error("send done lost");

  AST_TX_ONLY: assert property (@(posedge clk) disable iff (reset)
    (!flags[0].sendDone && !sendOk[0])
    |=> !flags[0].sendDone)
    else $error("send done without event");

  AST_TXSUM_SLOT1: assert property (@(posedge clk) disable iff (reset)
    sendOk[1]
    |=> sendSum[1])
    else $error("summary bit one not set");

  // Recv-done flag and summary
  AST_RX_SET: assert property (@(posedge clk) disable iff (reset)
    recvOk[0]
    |=> flags[0].recvDone)
    else $error("recv done not set");

  AST_RX_ONLY: assert property (@(posedge clk) disable iff (reset)
    (!flags[0].recvDone && !recvOk[0])
    |=> !flags[0].recvDone)
    else $error("recv done without event");

  AST_RX_KEEP: assert property (@(posedge clk) disable iff (reset)
    (flags[0].recvDone && !(wrStrobe && wrData[0] &&
     (addr == `CMS_SCLR_BASE || addr == `CMS_RXSUM_CLR_OFS)))
    |=> flags[0].recvDone)
    else $error("recv done lost");

  AST_RXSUM_CLR: assert property (@(posedge clk) disable iff (reset)
    (!recvOk[0] && wrStrobe && addr == `CMS_RXSUM_CLR_OFS && wrData[0])
    |=> !recvSum[0])
    else $error("recv summary not cleared");

  // Read path
  AST_TXSUM_READ: assert property (@(posedge clk) disable iff (reset)
    (rdStrobe && addr == `CMS_TXSUM_OFS)
    |=> rdData[0] == $past(sendSum[0]))
    else $error("send summary read wrong");

  AST_STAT_READ: assert property (@(posedge clk) disable iff (reset)
    (rdStrobe && addr == `CMS_STAT_BASE)
    |=> rdData[3:0] == $past(flags[0]))
    else $error("status read wrong");

  AST_CTRL_READ: assert property (@(posedge clk) disable iff (reset)
    (rdStrobe && addr == `CMS_CTRL_BASE)
    |=> rdData[5:0] == $past(ctrl[0]))
    else $error("control read wrong");

  // Read data must not linger past its one cycle
  AST_RD_IDLE: assert property (@(posedge clk) disable iff (reset)
    !rdStrobe
    |=> rdData == '0)
    else $error("read data lingers");

  // Control register storage
  AST_CTRL_KEEP: assert property (@(posedge clk) disable iff (reset)
    !wrStrobe
    |=> $stable(ctrl[0]))
    else $error("control changed without write");

  AST_LEN_STORE: assert property (@(posedge clk) disable iff (reset)
    (wrStrobe && addr == `CMS_CTRL_BASE)
    |=> slotLength[3:0] == $past(wrData[3:0]))
    else $error("length not stored");

  AST_STRIDE: assert property (@(posedge clk) disable iff (reset)
    (wrStrobe && addr == `CMS_CTRL_BASE + `CMS_SLOT_STRIDE)
    |=> dirSend[1] == $past(wrData[4]) &&
        slotLength[7:4] == $past(wrData[3:0]))
    else $error("slot one control not stored");

  AST_GCFG: assert property (@(posedge clk) disable iff (reset)
    (wrStrobe && addr == `CMS_GCFG_OFS)
    |=> replaceEnable == $past(wrData[0]))
    else $error("replace enable not stored");

  // Interrupt follows an enabled send event
  AST_IRQ_SEND: assert property (@(posedge clk) disable iff (reset)
    (sendOk[0] && irqEn[0] && !(wrStrobe && addr == `CMS_IRQ_EN_OFS))
    |=> irq)
    else $error("interrupt missed");
endmodule

// ===== common/cms_defs.svh
`ifndef CMS_DEFS_SVH
`define CMS_DEFS_SVH
`define CMS_RXSUM_CLR_OFS 8'h4C
`define CMS_RXSUM_OFS 8'h50
`define CMS_TXSUM_CLR_OFS 8'h54
`define CMS_TXSUM_OFS 8'h58
`define CMS_CTRL_BASE 8'h5C
`define CMS_SCLR_BASE 8'h60
`define CMS_STAT_BASE 8'h64
`define CMS_SLOT_STRIDE 8'h0C
`define CMS_GCFG_OFS 8'h10
`define CMS_IRQ_STAT_OFS 8'h14
`define CMS_IRQ_EN_OFS 8'h18
`define CMS_IRQ_CLR_OFS 8'h1C
`define CMS_VERSION_OFS 8'h20
`define CMS_BIT_AUTO 5
`define CMS_BIT_DIR 4
`define CMS_BIT_OVW 3
`define CMS_BIT_LENW 2
`define CMS_BIT_SEND_DONE_FLAG 1
`define CMS_BIT_RECV_DONE_FLAG 0
`define CMS_RESET_VAL 32'h0000_0000
`endif

// ===== common/cms_pkg.sv
package cms_pkg;
  typedef struct packed {
    logic autoRecv;
    logic dirSend;
    logic [3:0] dlc;
  } cms_ctrl_s;
  typedef struct packed {
    logic replaced;
    logic lenMismatch;
    logic sendDone;
    logic recvDone;
  } cms_flags_s;
  typedef enum logic [1:0] {
    CMS_IDLE = 2'b01,
    CMS_READ = 2'b10
  } cms_rd_e;
endpackage

// ===== testbench/cms_engine_model.sv
`timescale 1ns/10ps
module cms_engine_model (
  input wire logic clk,          // Clock
  input wire logic go,           // Issue one event
  input wire logic [1:0] kind,   // 0 send, 1 recv, 2 replace
  input wire logic [1:0] slot,   // Target slot
  input wire logic [3:0] len,    // Frame length code
  output logic [3:0] sendOk,     // Send done pulse
  output logic [3:0] recvOk,     // Recv done pulse
  output logic [3:0] overwrote,  // Replace pulse
  output logic [3:0] rxLength    // Received length
);
  initial
  begin
    {sendOk, recvOk, overwrote, rxLength} = 16'h0000;
  end
  always @(posedge clk)
  begin
    sendOk <= (go && kind == 2'h0) ? 4'h1 << slot : 4'h0;
    recvOk <= (go && kind != 2'h0) ? 4'h1 << slot : 4'h0;
    overwrote <= (go && kind == 2'h2) ? 4'h1 << slot : 4'h0;
    // Length is meaningless outside a frame, so it keeps toggling
    rxLength <= go ? len : ~rxLength;
  end
endmodule

// ===== testbench/cms_msg_slot_tb.sv
`timescale 1ns/10ps
module cms_msg_slot_tb;
  logic clk = 0, reset = 1, wrStrobe = 0, rdStrobe = 0, go = 0;
  logic [7:0] addr = 8'h00, r = 8'h4B;
  logic [31:0] wrData = 32'h0, rdData, d;
  logic [1:0] kind = 2'h0, slot = 2'h0, s;
  logic [3:0] len = 4'h0, l, m, sendOk, recvOk, overwrote, rxLength;
  logic [3:0] autoRecv, dirSend;
  logic [15:0] slotLength;
  logic replaceEnable, irq;
  int n_mismatch = 0, comparisons = 0, cyc = 0;
  always #4 clk = ~clk;
  cms_engine_model pm (.clk(clk), .go(go), .kind(kind), .slot(slot),
    .len(len), .sendOk(sendOk), .recvOk(recvOk), .overwrote(overwrote),
    .rxLength(rxLength));
  cms_msg_slot #(.SLOTS(4)) dut (.clk(clk), .reset(reset), .addr(addr),
    .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
    .rdData(rdData), .sendOk(sendOk), .recvOk(recvOk),
    .overwrote(overwrote), .rxLength(rxLength), .autoRecv(autoRecv),
    .dirSend(dirSend), .slotLength(slotLength),
    .replaceEnable(replaceEnable), .irq(irq));
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic logic [7:0] ofs(input logic [1:0] n, input logic [7:0] b);
    return b + 8'h0C * n;
  endfunction
  task automatic summarize;
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    addr <= a;
    wrData <= v;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, string nm);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    #1 d = rdData;
    chk(nm, d, e);
    @(posedge clk);
  endtask
  task automatic ev(input logic [1:0] k, n, input logic [3:0] ln);
    kind <= k;
    slot <= n;
    len <= ln;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      summarize();
    end
  end
  initial
  begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rc(8'h58, 32'h0, "sendsum");
    rc(8'h04, 32'h0, "unmapped");
    wr(8'h08, 32'hF);
    rc(8'h64, 32'h0, "status");
    for (int i = 0; i < 8; i++)
    begin
      r = lfsr(r);
      s = r[1:0];
      l = r[3:0] % 9;
      m = r[7] ? l : (l + 1) % 9;
      wr(ofs(s, 8'h5C), {r[5:4], l});
      rc(ofs(s, 8'h5C), {r[5:4], l}, "ctrl");
      chk("auto", autoRecv[s], r[5]);
      chk("dir", dirSend[s], r[4]);
      chk("len", slotLength[4*s+:4], l);
      ev(2'h0, s, l);
      rc(8'h58, 32'h1 << s, "sendsum");
      rc(ofs(s, 8'h64), 32'h2, "status");
      wr(ofs(s, 8'h60), 32'hD);
      rc(ofs(s, 8'h64), 32'h2, "status");
      wr(8'h54, 32'h0);
      rc(8'h58, 32'h1 << s, "sendsum");
      wr(8'h54, 32'h1 << s);
      rc(ofs(s, 8'h64), 32'h0, "status");
      ev(2'h1, s, m);
      rc(8'h50, 32'h1 << s, "recvsum");
      rc(ofs(s, 8'h64), {m != l, 2'b01}, "status");
      wr(ofs(s, 8'h60), 32'h5);
      rc(ofs(s, 8'h64), 32'h0, "status");
    end
    // Replace event is ignored until the global enable is set
    wr(8'h5C, 32'h0);
    ev(2'h2, 2'h0, 4'h0);
    rc(8'h64, 32'h1, "status");
    wr(8'h60, 32'hF);
    wr(8'h10, 32'h1);
    chk("repen", replaceEnable, 1'b1);
    ev(2'h2, 2'h0, 4'h0);
    wr(8'h60, 32'h7);
    rc(8'h64, 32'h8, "status");
    wr(8'h60, 32'h8);
    rc(8'h64, 32'h0, "status");
    kind <= 2'h0;
    slot <= 2'h0;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    wr(8'h54, 32'h1);
    rc(8'h58, 32'h1, "sendsum");
    wr(8'h1C, 32'hF);
    wr(8'h18, 32'h1);
    chk("irq", irq, 1'b0);
    ev(2'h0, 2'h2, 4'h0);
    chk("irq", irq, 1'b1);
    rc(8'h14, 32'h1, "irqstat");
    wr(8'h18, 32'h0);
    chk("irq", irq, 1'b0);
    wr(8'h18, 32'h1);
    wr(8'h1C, 32'h1);
    chk("irq", irq, 1'b0);
    rc(8'h18, 32'h1, "irqen");
    ev(2'h1, 2'h3, 4'h0);
    rc(8'h50, 32'h8, "recvsum");
    wr(8'h4C, 32'h8);
    rc(8'h50, 32'h0, "recvsum");
    summarize();
  end
endmodule
